// *** hw/tsw_pkg.sv ***
/*
 * constants for the setup word zero decoder: bus map, field layout,
 * reset value, status layout and timing figures.
 * assumes a 50 MHz system clock and 32-bit AXI4-Lite data.
 */
package tsw_pkg;

    // ************************************************************
    // bus map
    // ************************************************************
    localparam logic [31:0] SETUP_ADDR  = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
    localparam logic [31:0] SETUP_RESET = 32'h0100_2000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ************************************************************
    // field layout of the setup word
    // ************************************************************
    localparam int FIRE_CNT_LSB  = 28;
    localparam int FIRE_DIV_LSB  = 24;
    localparam int CALRES_LSB    = 22;
    localparam int CLKDIV_LSB    = 20;
    localparam int OSC_START_LSB = 18;
    localparam int PORT_BIT      = 17;
    localparam int TEMP_CYC_BIT  = 16;
    localparam int DUMMY_BIT     = 15;
    localparam int ECLK_BIT      = 14;
    localparam int CAL_BIT       = 13;
    localparam int NO_AUTO_BIT   = 12;
    localparam int RANGE_BIT     = 11;
    localparam int STOP_B_BIT    = 10;
    localparam int STOP_A_BIT    = 9;
    localparam int START_BIT     = 8;
    localparam int TAG_LSB       = 0;

    // ************************************************************
    // status layout
    // ************************************************************
    localparam int ST_PENDING  = 0;
    localparam int ST_DIV_BAD  = 1;
    localparam int ST_CAL_BAD  = 2;
    localparam int ST_OSC_ON   = 3;
    localparam int ST_FIRE_LSB = 8;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 20;
    localparam int SETTLE_A_NS      = 480_000;
    localparam int SETTLE_B_NS      = 1_460_000;
    localparam int SETTLE_C_NS      = 2_440_000;
    localparam int SETTLE_D_NS      = 5_140_000;
    localparam int SETTLE_A_CYC     = (SETTLE_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_B_CYC     = (SETTLE_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_C_CYC     = (SETTLE_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_D_CYC     = (SETTLE_D_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TEMP_CLK_MHZ     = 4;
    localparam int TEMP_SHORT_US    = 128;
    localparam int TEMP_LONG_US     = 512;
    localparam logic [11:0] TEMP_SHORT_TICKS = 12'(TEMP_SHORT_US * TEMP_CLK_MHZ);
    localparam logic [11:0] TEMP_LONG_TICKS  = 12'(TEMP_LONG_US * TEMP_CLK_MHZ);
    localparam logic [7:0]  ECLK_FAST_PERIOD = 8'h80;
    localparam logic [2:0]  TEMP_PORTS_FEW   = 3'h2;
    localparam logic [2:0]  TEMP_PORTS_MANY  = 3'h4;
    localparam logic [2:0]  DUMMY_FEW        = 3'h2;
    localparam logic [2:0]  DUMMY_MANY       = 3'h7;

endpackage

// *** hw/tsw_setup_word_zero.sv ***
/*
 * setup word zero of the two-channel converter: AXI4-Lite register,
 * shadow load at measurement start and decoding into control settings.
 * assumes the measurement sequencer pulses meas_start_i for one cycle
 * and the upper fire-count and oscillator bits come from another word.
 */
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - fire count drives pulses; zero disables generator
// - fire clock divided by field plus one
// - calibration periods 2,4,8,16 per code
// - fast clock divided by 1,2,4,4
// - oscillator off, on, or settle wait
// - start mode top bit from other word
// - temperature ports two or four
// - temperature cycle 128 or 512 us
// - two or seven dummy temperature measurements
// - cycle clock 32k or 128 fast periods
// - ALU calibration enable, off only range 1; off in range two is still passed on, only flagged in status
// - automatic calibration unless disable bit set
// - range two select picks measurement range
// - polarity bits invert start and stops
// - free tag bits stored, read back only
module tsw_setup_word_zero #(
    parameter int SETTLE_A = tsw_pkg::SETTLE_A_CYC,
    parameter int SETTLE_B = tsw_pkg::SETTLE_B_CYC,
    parameter int SETTLE_C = tsw_pkg::SETTLE_C_CYC,
    parameter int SETTLE_D = tsw_pkg::SETTLE_D_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_awaddr_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    output logic [1:0]       s_axi_bresp_o,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    input  wire logic [31:0] s_axi_araddr_i,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    input  wire logic        meas_start_i,
    input  wire logic [2:0]  fire_count_high_i,
    input  wire logic        osc_start_high_i,
    output logic [6:0]       fire_pulse_count_o,
    output logic             fire_gen_enable_o,
    output logic [4:0]       fire_clock_divisor_o,
    output logic [4:0]       resonator_cal_periods_o,
    output logic [2:0]       fast_clock_predivider_o,
    output logic [2:0]       oscillator_start_mode_o,
    output logic             osc_enable_o,
    output logic [18:0]      osc_settle_cycles_o,
    output logic [2:0]       temp_port_count_o,
    output logic [11:0]      temp_cycle_ticks_o,
    output logic [2:0]       temp_dummy_count_o,
    output logic             temp_cycle_clock_select_o,
    output logic [7:0]       temp_cycle_fast_periods_o,
    output logic             alu_cal_enable_o,
    output logic             auto_cal_enable_o,
    output logic             range_two_select_o,
    output logic             stop_a_invert_o,
    output logic             stop_b_invert_o,
    output logic             start_input_invert_o
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic [2:0] fast_div(input logic [1:0] code);
        unique case (code)
            2'h0:    fast_div = 3'h1;
            2'h1:    fast_div = 3'h2;
            default: fast_div = 3'h4;
        endcase
    endfunction

    function automatic logic [18:0] settle_cycles(input logic [2:0] mode);
        unique case (mode)
            3'h0, 3'h1: settle_cycles = 19'h0;
            3'h2:       settle_cycles = 19'(SETTLE_A);
            3'h3:       settle_cycles = 19'(SETTLE_B);
            3'h4:       settle_cycles = 19'(SETTLE_C);
            default:    settle_cycles = 19'(SETTLE_D);
        endcase
    endfunction

    function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] base);
        reg_hit = (addr[31:2] == base[31:2]);
    endfunction

    // ************************************************************
    // register storage
    // ************************************************************
    logic [31:0] setup_word;
    logic        pending;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        setup_write;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic [2:0]  next_mode;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign do_write        = aw_held && w_held && !s_axi_bvalid_o;
    assign setup_write     = do_write && reg_hit(aw_addr, tsw_pkg::SETUP_ADDR);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held <= 1'b0;
            aw_addr <= 32'h0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= tsw_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= setup_write ? tsw_pkg::RESP_OKAY : tsw_pkg::RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // byte-lane write; free tag bits are just stored
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            setup_word <= tsw_pkg::SETUP_RESET;
        end else if (setup_write) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b]) begin
                    setup_word[8*b +: 8] <= w_data[8*b +: 8];
                end
            end
        end
    end

    // a write in the same cycle as a start keeps pending set
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending <= 1'b0;
        end else if (setup_write) begin
            pending <= 1'b1;
        end else if (meas_start_i) begin
            pending <= 1'b0;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    always_comb begin
        status_word                                 = 32'h0;
        status_word[tsw_pkg::ST_PENDING]            = pending;
        status_word[tsw_pkg::ST_DIV_BAD]            = (fire_clock_divisor_o == 5'h1);
        status_word[tsw_pkg::ST_CAL_BAD]            = !alu_cal_enable_o && range_two_select_o;
        status_word[tsw_pkg::ST_OSC_ON]             = osc_enable_o;
        status_word[tsw_pkg::ST_FIRE_LSB +: 7]      = fire_pulse_count_o;
        if (reg_hit(s_axi_araddr_i, tsw_pkg::SETUP_ADDR)) begin
            next_rdata = setup_word;
        end else if (reg_hit(s_axi_araddr_i, tsw_pkg::STATUS_ADDR)) begin
            next_rdata = status_word;
        end else begin
            next_rdata = 32'h0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0;
            s_axi_rresp_o  <= tsw_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= next_rdata;
            if (reg_hit(s_axi_araddr_i, tsw_pkg::SETUP_ADDR)
                || reg_hit(s_axi_araddr_i, tsw_pkg::STATUS_ADDR)) begin
                s_axi_rresp_o <= tsw_pkg::RESP_OKAY;
            end else begin
                s_axi_rresp_o <= tsw_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ************************************************************
    // decoded settings, loaded at measurement start
    // ************************************************************
    assign next_mode = {osc_start_high_i, setup_word[tsw_pkg::OSC_START_LSB +: 2]};

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fire_pulse_count_o        <= 7'h0;
            fire_gen_enable_o         <= 1'b0;
            fire_clock_divisor_o      <= 5'h2;
            resonator_cal_periods_o   <= 5'h2;
            fast_clock_predivider_o   <= 3'h1;
            oscillator_start_mode_o   <= 3'h0;
            osc_enable_o              <= 1'b0;
            osc_settle_cycles_o       <= 19'h0;
            temp_port_count_o         <= tsw_pkg::TEMP_PORTS_FEW;
            temp_cycle_ticks_o        <= tsw_pkg::TEMP_SHORT_TICKS;
            temp_dummy_count_o        <= tsw_pkg::DUMMY_FEW;
            temp_cycle_clock_select_o <= 1'b0;
            temp_cycle_fast_periods_o <= 8'h0;
            alu_cal_enable_o          <= 1'b1;
            auto_cal_enable_o         <= 1'b1;
            range_two_select_o        <= 1'b0;
            stop_a_invert_o           <= 1'b0;
            stop_b_invert_o           <= 1'b0;
            start_input_invert_o      <= 1'b0;
        end else if (meas_start_i) begin
            fire_pulse_count_o <= {fire_count_high_i, setup_word[tsw_pkg::FIRE_CNT_LSB +: 4]};
            fire_gen_enable_o  <= ({fire_count_high_i,
                                   setup_word[tsw_pkg::FIRE_CNT_LSB +: 4]} != 7'h0);
            fire_clock_divisor_o <= {1'b0, setup_word[tsw_pkg::FIRE_DIV_LSB +: 4]} + 5'h1;
            resonator_cal_periods_o <= 5'h2 << setup_word[tsw_pkg::CALRES_LSB +: 2];
            fast_clock_predivider_o <= fast_div(setup_word[tsw_pkg::CLKDIV_LSB +: 2]);
            oscillator_start_mode_o <= next_mode;
            osc_enable_o            <= (next_mode != 3'h0);
            osc_settle_cycles_o     <= settle_cycles(next_mode);
            temp_port_count_o  <= setup_word[tsw_pkg::PORT_BIT] ?
                                  tsw_pkg::TEMP_PORTS_MANY : tsw_pkg::TEMP_PORTS_FEW;
            temp_cycle_ticks_o <= setup_word[tsw_pkg::TEMP_CYC_BIT] ?
                                  tsw_pkg::TEMP_LONG_TICKS : tsw_pkg::TEMP_SHORT_TICKS;
            temp_dummy_count_o <= setup_word[tsw_pkg::DUMMY_BIT] ?
                                  tsw_pkg::DUMMY_MANY : tsw_pkg::DUMMY_FEW;
            temp_cycle_clock_select_o <= setup_word[tsw_pkg::ECLK_BIT];
            temp_cycle_fast_periods_o <= setup_word[tsw_pkg::ECLK_BIT] ?
                                         tsw_pkg::ECLK_FAST_PERIOD : 8'h0;
            alu_cal_enable_o     <= setup_word[tsw_pkg::CAL_BIT];
            auto_cal_enable_o    <= !setup_word[tsw_pkg::NO_AUTO_BIT];
            range_two_select_o   <= setup_word[tsw_pkg::RANGE_BIT];
            stop_b_invert_o      <= setup_word[tsw_pkg::STOP_B_BIT];
            stop_a_invert_o      <= setup_word[tsw_pkg::STOP_A_BIT];
            start_input_invert_o <= setup_word[tsw_pkg::START_BIT];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_fire_count_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i |=> fire_pulse_count_o == {$past(fire_count_high_i),
        $past(setup_word[31:28])} && fire_gen_enable_o == (fire_pulse_count_o != 7'h0))
        else $error("fire count not loaded at start");
    a_fire_gen_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && fire_count_high_i == 3'h0 && setup_word[31:28] == 4'h0
        |=> !fire_gen_enable_o)
        else $error("fire generator not off");
    a_fire_div_plus: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i |=> fire_clock_divisor_o == {1'b0, $past(setup_word[27:24])} + 5'h1)
        else $error("fire divisor wrong");
    a_calres_periods: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && setup_word[23:22] == 2'h3 |=> resonator_cal_periods_o == 5'h10)
        else $error("calibration periods wrong");
    a_fast_div_code: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && setup_word[21] |=> fast_clock_predivider_o == 3'h4)
        else $error("fast predivider wrong");
    a_osc_settle_max: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && osc_start_high_i && setup_word[18] |=>
        osc_settle_cycles_o == 19'(SETTLE_D) && osc_enable_o)
        else $error("settle wait wrong");
    a_osc_off_mode: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && !osc_start_high_i && setup_word[19:18] == 2'h0
        |=> !osc_enable_o && osc_settle_cycles_o == 19'h0)
        else $error("oscillator not off");
    a_temp_setup: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && setup_word[17] && setup_word[15] |=>
        temp_port_count_o == 3'h4 && temp_dummy_count_o == 3'h7)
        else $error("temperature setup wrong");
    a_ticks_long: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && setup_word[16] |=> temp_cycle_ticks_o == 12'h800)
        else $error("long temperature cycle wrong");
    a_dummy_few: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && !setup_word[15] |=> temp_dummy_count_o == 3'h2)
        else $error("dummy count wrong");
    a_eclk_period: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && setup_word[14] |=> temp_cycle_clock_select_o && temp_cycle_fast_periods_o == 8'h80)
        else $error("cycle clock period wrong");
    a_range_cal: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i |=> alu_cal_enable_o == $past(setup_word[13])
        && range_two_select_o == $past(setup_word[11]))
        else $error("calibration or range wrong");
    a_stop_invert: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i |=> stop_a_invert_o == $past(setup_word[9])
        && stop_b_invert_o == $past(setup_word[10]))
        else $error("stop polarity wrong");
    a_settings_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !meas_start_i |=> $stable(alu_cal_enable_o) && $stable(stop_a_invert_o)
        && $stable(temp_cycle_ticks_o) && $stable(range_two_select_o))
        else $error("setting moved without start");
    a_pending_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        setup_write |=> pending)
        else $error("pending flag lost");
    a_pending_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i && !setup_write |=> !pending)
        else $error("pending flag not cleared");
    a_write_answer: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        do_write |=> s_axi_bvalid_o && s_axi_bresp_o == (($past(setup_write)) ?
        tsw_pkg::RESP_OKAY : tsw_pkg::RESP_SLVERR))
        else $error("write answer wrong");
    a_auto_cal: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_start_i |=> auto_cal_enable_o != $past(setup_word[12])
        && start_input_invert_o == $past(setup_word[8]))
        else $error("auto calibration or polarity wrong");

endmodule

`default_nettype wire

// *** sim/test_tsw_setup_word_zero.sv ***
/*
 * self-checking bench for the setup word zero decoder: AXI4-Lite access
 * tasks, decode sweep over eight setup words, lane writes and refusals.
 * assumes hw/tsw_pkg.sv and hw/tsw_setup_word_zero.sv are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module test_tsw_setup_word_zero;

    // ************************************************************
    // signals and design
    // ************************************************************
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        awv = 1'b0, awr, wv = 1'b0, wr, bv, bready = 1'b0;
    logic        arv = 1'b0, arr, rv, rready = 1'b0, mst = 1'b0, osc_hi = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic [1:0]  bresp, rresp;
    logic [2:0]  fire_hi = '0;
    logic [6:0]  o_fire;
    logic [4:0]  o_div, o_cal;
    logic [2:0]  o_pre, o_mode, o_ports, o_dummy;
    logic [18:0] o_settle;
    logic [11:0] o_ticks;
    logic [7:0]  o_per;
    logic        o_fen, o_osc, o_eclk, o_alu, o_auto, o_rng, o_sb, o_sa, o_st;
    int          n_errors = 0;
    int          tests_run = 0;
    logic [31:0] w, pw;

    tsw_setup_word_zero #(.SETTLE_A(10), .SETTLE_B(20), .SETTLE_C(30), .SETTLE_D(40)) DUT (
        .clk_sys_i(clk), .resetn_i(rstn),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awaddr),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
        .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .meas_start_i(mst),
        .fire_count_high_i(fire_hi), .osc_start_high_i(osc_hi),
        .fire_pulse_count_o(o_fire), .fire_gen_enable_o(o_fen),
        .fire_clock_divisor_o(o_div), .resonator_cal_periods_o(o_cal),
        .fast_clock_predivider_o(o_pre), .oscillator_start_mode_o(o_mode),
        .osc_enable_o(o_osc), .osc_settle_cycles_o(o_settle),
        .temp_port_count_o(o_ports), .temp_cycle_ticks_o(o_ticks),
        .temp_dummy_count_o(o_dummy), .temp_cycle_clock_select_o(o_eclk),
        .temp_cycle_fast_periods_o(o_per), .alu_cal_enable_o(o_alu),
        .auto_cal_enable_o(o_auto), .range_two_select_o(o_rng),
        .stop_a_invert_o(o_sa), .stop_b_invert_o(o_sb), .start_input_invert_o(o_st));

    initial begin
        forever #10 clk = ~clk;
    end

    // ************************************************************
    // compare, verdict and bus tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic axw(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        logic [1:0] rsp;
        awaddr <= a; wdata <= d; wstrb <= s; awv <= 1'b1; wv <= 1'b1;
        n = 0; ta = 1'b0; tw = 1'b0; tb = 1'b0; rsp = '0;
        while (!(ta && tw) && n < 50) begin
            #1;
            if (awv && awr) ta = 1'b1;
            if (wv && wr) tw = 1'b1;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            n++;
        end
        bready <= 1'b1;
        while (!tb && n < 100) begin
            #1;
            tb = bv;
            rsp = bresp;
            @(posedge clk);
            n++;
        end
        bready <= 1'b0;
        if (!tb) begin
            n_errors++;
            give_verdict();
        end
        chk("bresp", 32'(er), 32'(rsp));
    endtask

    task automatic axr(input logic [31:0] a, e, m, input logic [1:0] er);
        int n;
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] rsp;
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        n = 0; ta = 1'b0; tr = 1'b0; d = '0; rsp = '0;
        while (!tr && n < 50) begin
            #1;
            tr = rv && ta;
            d = rdata;
            rsp = rresp;
            if (arv && arr) ta = 1'b1;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        @(posedge clk);
        if (!tr) begin
            n_errors++;
            give_verdict();
        end
        chk("rdata", e & m, d & m);
        chk("rresp", 32'(er), 32'(rsp));
    endtask

    // decoded outputs against a word and the two upper inputs
    task automatic dec(input logic [31:0] x, input logic [2:0] fh, input logic oh);
        logic [6:0] f;
        logic [2:0] md;
        f = {fh, x[31:28]};
        md = {oh, x[19:18]};
        chk("fire", 32'(f), 32'(o_fire));
        chk("fire_en", 32'(f != 7'h00), 32'(o_fen));
        chk("fire_div", 32'(5'(x[27:24]) + 5'h01), 32'(o_div));
        chk("cal_per", 32'(5'h02 << x[23:22]), 32'(o_cal));
        chk("predv", x[21:20] == 2'h0 ? 32'h1 : x[21:20] == 2'h1 ? 32'h2 : 32'h4,
            32'(o_pre));
        chk("osc_mode", 32'(md), 32'(o_mode));
        chk("osc_en", 32'(md != 3'h0), 32'(o_osc));
        chk("settle", md < 3'h2 ? 32'h0 : md == 3'h2 ? 32'ha : md == 3'h3 ? 32'h14 :
            md == 3'h4 ? 32'h1e : 32'h28, 32'(o_settle));
        chk("ports", x[17] ? 32'h4 : 32'h2, 32'(o_ports));
        chk("ticks", x[16] ? 32'h800 : 32'h200, 32'(o_ticks));
        chk("dummy", x[15] ? 32'h7 : 32'h2, 32'(o_dummy));
        chk("eclk", {31'h0, x[14]}, 32'(o_eclk));
        chk("fast_per", x[14] ? 32'h80 : 32'h0, 32'(o_per));
        chk("alu_cal", {31'h0, x[13]}, 32'(o_alu));
        chk("auto_cal", {31'h0, !x[12]}, 32'(o_auto));
        chk("range", {31'h0, x[11]}, 32'(o_rng));
        chk("inv", 32'(x[10:8]), 32'({o_sb, o_sa, o_st}));
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        dec(tsw_pkg::SETUP_RESET, 3'h0, 1'b0);
        @(posedge clk);
        axr(tsw_pkg::SETUP_ADDR, tsw_pkg::SETUP_RESET, 32'hffffffff, 2'h0);
        axr(32'h0000_0008, 32'h0, 32'hffffffff, 2'h2);
        axw(tsw_pkg::STATUS_ADDR, 32'hffffffff, 4'hf, 2'h2);
        axr(tsw_pkg::SETUP_ADDR, tsw_pkg::SETUP_RESET, 32'hffffffff, 2'h0);
        pw = tsw_pkg::SETUP_RESET;
        for (int i = 0; i < 8; i++) begin
            w = {4'(i == 7 ? 15 : i * 2), 4'(i), 2'(i), 2'(i >> 1), 2'(i),
                 (i % 2 == 1) ? 10'h2aa : 10'h155, 8'(i * 37)};
            axw(tsw_pkg::SETUP_ADDR, w, 4'hf, 2'h0);
            axr(tsw_pkg::SETUP_ADDR, w, 32'hffffffff, 2'h0);
            axr(tsw_pkg::STATUS_ADDR, 32'h1, 32'h1, 2'h0);
            #1;
            dec(pw, fire_hi, osc_hi);
            @(posedge clk);
            fire_hi <= 3'(i);
            osc_hi <= i[2];
            mst <= 1'b1;
            @(posedge clk);
            mst <= 1'b0;
            #1;
            dec(w, 3'(i), i[2]);
            pw = w;
            @(posedge clk);
            axr(tsw_pkg::STATUS_ADDR, {17'h0, fire_hi, w[31:28], 4'h0,
                osc_hi || w[19:18] != 2'h0, !w[13] && w[11], w[27:24] == 4'h0, 1'b0},
                32'hffffffff, 2'h0);
        end
        axw(tsw_pkg::SETUP_ADDR, 32'hffffffff, 4'h1, 2'h0);
        axr(tsw_pkg::SETUP_ADDR, w | 32'hff, 32'hffffffff, 2'h0);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        axr(tsw_pkg::SETUP_ADDR, tsw_pkg::SETUP_RESET, 32'hffffffff, 2'h0);
        dec(tsw_pkg::SETUP_RESET, 3'h0, 1'b0);
        give_verdict();
    end

endmodule

`default_nettype wire
